// File: design/odsig_pkg.sv
// Package for the option DMA setup, interrupt and general-purpose I/O block.
// Assumes one 100 MHz clock; the option pins are asynchronous to it.
package odsig_pkg;

	localparam int          WORD_W      = 32;
	localparam int          IRQ_W       = 26;
	localparam int          FIFO_DEPTH  = 15;
	localparam logic [3:0]  FIFO_LAST   = 4'he;
	// Room kept for words still in flight through the pin synchronisers
	localparam logic [3:0]  SPACE_LIMIT = 4'hc;
	localparam logic [31:0] ADDR_STEP   = 32'h0000_0004;

	// Register offsets
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_MASK   = 8'h04;
	localparam logic [7:0] OFF_CTRL   = 8'h08;
	localparam logic [7:0] OFF_RDP    = 8'h0c;
	localparam logic [7:0] OFF_TDP    = 8'h10;
	localparam logic [7:0] OFF_TWC    = 8'h14;
	localparam logic [7:0] OFF_BURST  = 8'h18;
	localparam logic [7:0] OFF_PMASK  = 8'h1c;

	// Control register fields
	localparam int CTRL_GPO_LSB = 0;
	localparam int CTRL_PAR_EN  = 8;
	localparam int CTRL_RX_EN   = 9;
	localparam int CTRL_TX_EN   = 10;

	// Status bit positions; bits 3..0 follow the general inputs
	localparam int ST_GPI_W    = 4;
	localparam int ST_OPT_PAR  = 4;
	localparam int ST_SYS_PAR  = 5;
	localparam int ST_TX_DONE  = 6;
	localparam int ST_RXA_LOAD = 7;
	localparam int ST_TXA_LOAD = 8;
	localparam int ST_CTL_LOAD = 9;

	// Values after reset
	localparam logic [25:0] MASK_RST  = 26'h0;
	localparam logic [31:0] CTRL_RST  = 32'h0;
	localparam logic [31:0] PMASK_RST = 32'hffff_ffff;

	typedef enum logic [1:0] {
		ODSIG_TAG_DATA = 2'h0,
		ODSIG_TAG_RXA  = 2'h1,
		ODSIG_TAG_TXA  = 2'h2,
		ODSIG_TAG_CTL  = 2'h3
	} odsig_tag_t;

	typedef enum logic [3:0] {
		ODSIG_IDLE = 4'h1,
		ODSIG_PIO  = 4'h2,
		ODSIG_RXWR = 4'h4,
		ODSIG_TXRD = 4'h8
	} odsig_own_t;

	typedef struct packed {
		odsig_tag_t  tag;
		logic [31:0] word;
	} odsig_entry_t;

	typedef struct packed {
		logic        clk;
		logic        rx_addr_load_n;
		logic        tx_addr_load_n;
		logic        rx_data_strobe_n;
		logic        tx_dack_n;
		logic        par;
		logic [31:0] option_bus;
		logic [3:0]  gp_inputs;
	} odsig_opin_t;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} odsig_sys_t;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        wpar;
	} odsig_mem_t;

endpackage

// File: design/odsig_top.sv
// Option-side DMA setup words, interrupt aggregation, parity and GPIO.
// Assumes system requests and memory answers share mclk; option pins do not.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module odsig_top (
	input  wire logic                  mclk,
	input  wire logic                  rst_n,
	input  wire odsig_pkg::odsig_sys_t sys_in,
	output logic [31:0]                sys_rdata,
	output logic                       sys_ack,
	output odsig_pkg::odsig_mem_t      mem_out,
	input  wire logic [31:0]           mem_rdata,
	input  wire logic                  mem_rpar,
	input  wire logic                  mem_ack,
	input  wire odsig_pkg::odsig_opin_t opin,
	output logic                       rx_space_ok_n,
	output logic                       tx_valid_n,
	output logic [31:0]                tx_data,
	output logic                       tx_par,
	output logic [7:0]                 gp_outputs,
	output logic                       system_irq_n
);

	typedef struct packed {
		odsig_pkg::odsig_opin_t                s1;
		odsig_pkg::odsig_opin_t                s2;
		logic                                  clk_prev;
		odsig_pkg::odsig_entry_t [14:0]        fifo;
		logic [3:0]                            rd;
		logic [3:0]                            wr;
		logic [3:0]                            count;
		odsig_pkg::odsig_own_t                 own;
		odsig_pkg::odsig_mem_t                 mem;
		logic [31:0]                           rdata;
		logic                                  ack;
		logic [25:0]                           status;
		logic [25:0]                           mask;
		logic [31:0]                           ctrl;
		logic [31:0]                           rx_data_pointer;
		logic [31:0]                           tx_data_pointer;
		logic [23:0]                           tx_word_count;
		logic [7:0]                            burst;
		logic [31:0]                           pmask;
		logic [31:0]                           tx_hold;
		logic                                  tx_par;
		logic                                  tx_full;
		logic                                  rx_turn;
	} odsig_state_t;

	odsig_state_t state_reg;
	odsig_state_t state_next;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [3:0] odsig_step(input logic [3:0] p);
		odsig_step = (p == odsig_pkg::FIFO_LAST) ? 4'h0 : 4'(p + 4'h1);
	endfunction

	function automatic logic [31:0] odsig_merge(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [31:0] m);
		odsig_merge = (old_v & ~m) | (new_v & m);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		odsig_state_t           r;
		odsig_state_t           n;
		odsig_pkg::odsig_entry_t head;
		odsig_pkg::odsig_tag_t  tag;
		logic                   op_edge;
		logic                   push;
		logic                   pop;
		logic                   par_en;
		logic                   head_ok;
		logic                   rx_want;
		logic                   tx_want;
		logic [25:0]            set_bits;
		logic [25:0]            clr_bits;
		r = state_reg;
		n = state_reg;
		head = r.fifo[r.rd];
		tag = odsig_pkg::ODSIG_TAG_DATA;
		push = 1'b0;
		pop = 1'b0;
		op_edge = 1'b0;
		rx_want = 1'b0;
		tx_want = 1'b0;
		set_bits = 26'h0;
		clr_bits = 26'h0;
		par_en = r.ctrl[odsig_pkg::CTRL_PAR_EN];
		head_ok = (r.count != 4'h0);

		// Option pins: two flops, then edge detect on the second stage
		n.s1 = opin;
		n.s2 = r.s1;
		n.clk_prev = r.s2.clk;
		op_edge = r.s2.clk & ~r.clk_prev;
		n.ack = 1'b0;

		// Shared bus: one owner at a time
		rx_want = head_ok && (head.tag == odsig_pkg::ODSIG_TAG_DATA) &&
			r.ctrl[odsig_pkg::CTRL_RX_EN];
		tx_want = (r.tx_word_count != 24'h0) && !r.tx_full &&
			r.ctrl[odsig_pkg::CTRL_TX_EN];
		case (r.own)
			odsig_pkg::ODSIG_IDLE: begin
				// Register access first, then DMA in turn
				if (sys_in.req && !r.ack) begin
					n.own = odsig_pkg::ODSIG_PIO;
				end else if (rx_want && (r.rx_turn || !tx_want)) begin
					n.own = odsig_pkg::ODSIG_RXWR;
					n.rx_turn = 1'b0;
					n.mem.req = 1'b1;
					n.mem.we = 1'b1;
					n.mem.addr = r.rx_data_pointer;
					n.mem.wdata = head.word;
					n.mem.wpar = ~^head.word;
				end else if (tx_want) begin
					// Fills transmit side while option keeps queueing
					n.own = odsig_pkg::ODSIG_TXRD;
					n.rx_turn = 1'b1;
					n.mem.req = 1'b1;
					n.mem.we = 1'b0;
					n.mem.addr = r.tx_data_pointer;
					n.mem.wdata = 32'h0;
					n.mem.wpar = 1'b0;
				end
			end
			odsig_pkg::ODSIG_PIO: begin
				n.own = odsig_pkg::ODSIG_IDLE;
				n.ack = 1'b1;
				n.rdata = 32'h0;
				case (sys_in.addr)
					odsig_pkg::OFF_STATUS: begin
						// Live inputs in low bits, unmasked
						n.rdata = {6'h0, r.status[25:4], r.s2.gp_inputs};
						if (sys_in.we) begin
							clr_bits = sys_in.wdata[25:0];
						end
					end
					odsig_pkg::OFF_MASK: begin
						n.rdata = {6'h0, r.mask};
						if (sys_in.we) begin
							n.mask = sys_in.wdata[25:0];
						end
					end
					odsig_pkg::OFF_CTRL: begin
						n.rdata = r.ctrl;
						if (sys_in.we) begin
							n.ctrl = sys_in.wdata;
						end
					end
					odsig_pkg::OFF_RDP: begin
						n.rdata = r.rx_data_pointer;
						if (sys_in.we) begin
							n.rx_data_pointer = sys_in.wdata;
						end
					end
					odsig_pkg::OFF_TDP: begin
						n.rdata = r.tx_data_pointer;
						if (sys_in.we) begin
							n.tx_data_pointer = sys_in.wdata;
						end
					end
					odsig_pkg::OFF_TWC: begin
						n.rdata = {8'h0, r.tx_word_count};
						if (sys_in.we) begin
							n.tx_word_count = sys_in.wdata[23:0];
						end
					end
					odsig_pkg::OFF_BURST: begin
						n.rdata = {24'h0, r.burst};
						if (sys_in.we) begin
							n.burst = sys_in.wdata[7:0];
						end
					end
					odsig_pkg::OFF_PMASK: begin
						n.rdata = r.pmask;
						if (sys_in.we) begin
							n.pmask = sys_in.wdata;
						end
					end
					default: begin
						n.rdata = 32'h0;
					end
				endcase
			end
			odsig_pkg::ODSIG_RXWR: begin
				if (mem_ack) begin
					n.own = odsig_pkg::ODSIG_IDLE;
					n.mem.req = 1'b0;
					n.rx_data_pointer = r.rx_data_pointer + odsig_pkg::ADDR_STEP;
					pop = 1'b1;
				end
			end
			odsig_pkg::ODSIG_TXRD: begin
				if (mem_ack) begin
					n.own = odsig_pkg::ODSIG_IDLE;
					n.mem.req = 1'b0;
					n.tx_hold = mem_rdata;
					n.tx_par = ~^mem_rdata;
					n.tx_full = 1'b1;
					n.tx_data_pointer = r.tx_data_pointer + odsig_pkg::ADDR_STEP;
					n.tx_word_count = r.tx_word_count - 24'h1;
					if (r.tx_word_count == 24'h1) begin
						set_bits[odsig_pkg::ST_TX_DONE] = 1'b1;
					end
					if (par_en && !(^{mem_rdata, mem_rpar})) begin
						set_bits[odsig_pkg::ST_SYS_PAR] = 1'b1;
					end
				end
			end
			default: begin
				n.own = odsig_pkg::ODSIG_IDLE;
				n.mem.req = 1'b0;
			end
		endcase

		// Setup words are used up here and never reach memory
		if (head_ok) begin
			case (head.tag)
				odsig_pkg::ODSIG_TAG_RXA: begin
					n.rx_data_pointer = odsig_merge(r.rx_data_pointer, head.word, r.pmask);
					set_bits[odsig_pkg::ST_RXA_LOAD] = 1'b1;
					pop = 1'b1;
				end
				odsig_pkg::ODSIG_TAG_TXA: begin
					// Held at the head while a transmit count is running
					if (r.tx_word_count == 24'h0 && r.own != odsig_pkg::ODSIG_TXRD) begin
						n.tx_data_pointer = odsig_merge(r.tx_data_pointer, head.word, r.pmask);
						set_bits[odsig_pkg::ST_TXA_LOAD] = 1'b1;
						pop = 1'b1;
					end
				end
				odsig_pkg::ODSIG_TAG_CTL: begin
					if (r.own != odsig_pkg::ODSIG_TXRD) begin
						n.burst = head.word[31:24];
						n.tx_word_count = head.word[23:0];
						set_bits[odsig_pkg::ST_CTL_LOAD] = 1'b1;
						pop = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end

		// Capture on the option clock edge after a strobe
		if (!r.s2.rx_addr_load_n && r.s2.tx_addr_load_n) begin
			tag = odsig_pkg::ODSIG_TAG_RXA;
		end else if (r.s2.rx_addr_load_n && !r.s2.tx_addr_load_n) begin
			tag = odsig_pkg::ODSIG_TAG_TXA;
		end else if (!r.s2.rx_addr_load_n && !r.s2.tx_addr_load_n) begin
			tag = odsig_pkg::ODSIG_TAG_CTL;
		end
		if (op_edge && (!r.s2.rx_addr_load_n || !r.s2.tx_addr_load_n ||
				!r.s2.rx_data_strobe_n) &&
				r.count != 4'(odsig_pkg::FIFO_DEPTH)) begin
			n.fifo[r.wr] = '{tag: tag, word: r.s2.option_bus};
			n.wr = odsig_step(r.wr);
			push = 1'b1;
			if (par_en && !(^{r.s2.option_bus, r.s2.par})) begin
				set_bits[odsig_pkg::ST_OPT_PAR] = 1'b1;
			end
		end
		if (pop) begin
			n.rd = odsig_step(r.rd);
		end
		n.count = 4'(r.count + {3'h0, push} - {3'h0, pop});

		// Transmit word leaves on the option's acknowledge
		if (op_edge && !r.s2.tx_dack_n && r.tx_full) begin
			n.tx_full = 1'b0;
		end

		// Set wins over a same-cycle clear; low bits follow inputs
		n.status = (r.status & ~clr_bits) | set_bits;
		n.status[3:0] = r.s2.gp_inputs;
		state_next = n;
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_reg <= '0;
			state_reg.own <= odsig_pkg::ODSIG_IDLE;
			state_reg.mask <= odsig_pkg::MASK_RST;
			state_reg.ctrl <= odsig_pkg::CTRL_RST;
			state_reg.pmask <= odsig_pkg::PMASK_RST;
			state_reg.s1.rx_addr_load_n <= 1'b1;
			state_reg.s1.tx_addr_load_n <= 1'b1;
			state_reg.s1.rx_data_strobe_n <= 1'b1;
			state_reg.s1.tx_dack_n <= 1'b1;
			state_reg.s2.rx_addr_load_n <= 1'b1;
			state_reg.s2.tx_addr_load_n <= 1'b1;
			state_reg.s2.rx_data_strobe_n <= 1'b1;
			state_reg.s2.tx_dack_n <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign sys_rdata = state_reg.rdata;
	assign sys_ack = state_reg.ack;
	assign mem_out = state_reg.mem;
	// Threshold leaves room for strobes already in the synchroniser
	assign rx_space_ok_n = !(state_reg.count < odsig_pkg::SPACE_LIMIT);
	assign tx_valid_n = !state_reg.tx_full;
	assign tx_data = state_reg.tx_hold;
	assign tx_par = state_reg.tx_par;
	assign gp_outputs = state_reg.ctrl[odsig_pkg::CTRL_GPO_LSB +: 8];
	assign system_irq_n = !(|(state_reg.status & state_reg.mask));

endmodule

`default_nettype wire

// File: verif/odsig_top_monitor.sv
// Checker for odsig_top, bound to every instance of it.
// Sees only the top ports; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module odsig_top_monitor (
	input wire logic                   mclk,
	input wire logic                   rst_n,
	input wire odsig_pkg::odsig_sys_t  sys_in,
	input wire logic [31:0]            sys_rdata,
	input wire logic                   sys_ack,
	input wire odsig_pkg::odsig_mem_t  mem_out,
	input wire logic [31:0]            mem_rdata,
	input wire logic                   mem_rpar,
	input wire logic                   mem_ack,
	input wire odsig_pkg::odsig_opin_t opin,
	input wire logic                   rx_space_ok_n,
	input wire logic                   tx_valid_n,
	input wire logic [31:0]            tx_data,
	input wire logic                   tx_par,
	input wire logic [7:0]             gp_outputs,
	input wire logic                   system_irq_n
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////
	AST_ACK_PULSE: assert property (sys_ack |=> !sys_ack)
		else $error("register answer longer than one cycle");
	AST_ACK_REQ: assert property (sys_ack |-> sys_in.req)
		else $error("register answer without a request");
	// Bound covers a memory transaction already in flight
	AST_ACK_BOUND: assert property (
		$rose(sys_in.req) |-> ##[2:60] sys_ack)
		else $error("register request not answered");
	AST_MEM_HOLD: assert property (
		mem_out.req && !mem_ack |=> mem_out.req && $stable(mem_out))
		else $error("memory request changed before answer");
	AST_MEM_DROP: assert property (mem_ack |=> !mem_out.req)
		else $error("no idle cycle after memory answer");
	AST_WPAR: assert property (
		mem_out.req && mem_out.we |-> ^{mem_out.wdata, mem_out.wpar})
		else $error("memory write parity not odd");
	AST_TPAR: assert property (!tx_valid_n |-> ^{tx_data, tx_par})
		else $error("transmit word parity not odd");
	AST_RD_EMPTY: assert property (
		mem_out.req && !mem_out.we |-> tx_valid_n)
		else $error("read started while transmit word held");
	AST_TXV_CAUSE: assert property (
		$fell(tx_valid_n) |-> $past(mem_ack && !mem_out.we))
		else $error("transmit word without a memory read");
	AST_GPO: assert property (
		sys_ack && sys_in.we && sys_in.addr == odsig_pkg::OFF_CTRL
		|-> ##[0:1] gp_outputs == sys_in.wdata[7:0])
		else $error("outputs do not follow control write");
	AST_GPO_HOLD: assert property (
		$changed(gp_outputs) |-> $past(sys_in.req && sys_in.we))
		else $error("outputs changed without a write");

	cover property (mem_ack && mem_out.we);
	cover property (mem_ack && !mem_out.we);
	cover property (!system_irq_n);
endmodule

bind odsig_top odsig_top_monitor mon (.mclk, .rst_n, .sys_in, .sys_rdata,
	.sys_ack, .mem_out, .mem_rdata, .mem_rpar, .mem_ack, .opin,
	.rx_space_ok_n, .tx_valid_n, .tx_data, .tx_par, .gp_outputs,
	.system_irq_n);
`default_nettype wire

// File: verif/odsig_opt_model.sv
// Option-side partner: one option clock frame per word or drain.
// Pins are asynchronous to mclk; the option clock idles low between frames.
`timescale 1ns/1ps
`default_nettype none
module odsig_opt_model (
	input  wire logic              rx_space_ok_n,
	input  wire logic [3:0]        gpi,
	output odsig_pkg::odsig_opin_t opin
);
	initial begin
		opin.clk = 1'b0;
		{opin.tx_dack_n, opin.rx_data_strobe_n} = 2'h3;
		{opin.tx_addr_load_n, opin.rx_addr_load_n} = 2'h3;
		opin.option_bus = '0;
		opin.par = 1'b1;
		opin.gp_inputs = 4'h0;
	end
	always @(gpi) opin.gp_inputs = gpi;

	////////////////////////////////////////////////////////////////////////
	// strb_n is {drain, data, tx address, rx address}, all active low
	task automatic frame(input logic [3:0] strb_n, input logic [31:0] w,
		input logic bad);
		int k;
		k = 0;
		while (!(&strb_n[2:0]) && rx_space_ok_n !== 1'b0 &&
				k < 500) begin
			#10;
			k++;
		end
		{opin.tx_dack_n, opin.rx_data_strobe_n, opin.tx_addr_load_n,
			opin.rx_addr_load_n} = strb_n;
		opin.option_bus = w;
		opin.par = ~^w ^ bad;
		#40 opin.clk = 1'b1;
		#40 opin.clk = 1'b0;
		{opin.tx_dack_n, opin.rx_data_strobe_n} = 2'h3;
		{opin.tx_addr_load_n, opin.rx_addr_load_n} = 2'h3;
		// Released bus shows the inverse so a stale word is never taken
		opin.option_bus = ~w;
		opin.par = ~opin.par;
		#40;
	endtask
endmodule
`default_nettype wire

// File: verif/odsig_tb_top.sv
// Bench for odsig_top: register tasks, memory responder, option model.
// Assumes a 100 MHz mclk and the option model for the far side.
`timescale 1ns/1ps
`default_nettype none
module odsig_tb_top;
	logic                   mclk, rst_n, mem_rpar, mem_ack, go, txv_q;
	odsig_pkg::odsig_sys_t  sys_in;
	odsig_pkg::odsig_mem_t  mem_out;
	odsig_pkg::odsig_opin_t opin;
	logic [31:0]            sys_rdata, mem_rdata, tx_data, rd, w, q, p, a, m;
	logic [7:0]             gp_outputs;
	logic [3:0]             gpi;
	logic                   sys_ack, rx_space_ok_n, tx_valid_n, tx_par;
	logic                   system_irq_n, rbad;
	// Responder data kept apart from the scenario words
	logic [31:0]            rv;
	int                     seed = 29, n_errors = 0, checked = 0, cyc = 0;
	logic [63:0]            wq[$];
	logic [31:0]            rq[$];

	odsig_top dut (.mclk, .rst_n, .sys_in, .sys_rdata, .sys_ack, .mem_out,
		.mem_rdata, .mem_rpar, .mem_ack, .opin, .rx_space_ok_n, .tx_valid_n,
		.tx_data, .tx_par, .gp_outputs, .system_irq_n);
	odsig_opt_model opt (.rx_space_ok_n, .gpi, .opin);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic acc(input logic we, input logic [7:0] ad,
		input logic [31:0] d);
		int k;
		@(posedge mclk);
		sys_in <= '{1'b1, we, ad, d};
		k = 0;
		do begin
			@(posedge mclk);
			#1;
			k++;
		end while (sys_ack !== 1'b1 && k < 99);
		rd = sys_rdata;
		@(posedge mclk);
		sys_in.req <= 1'b0;
		if (k == 99) chk(32'h0, 32'h1);
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		acc(1'b1, ad, d);
	endtask

	task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
		acc(1'b0, ad, '0);
		chk(rd, exp);
	endtask

	function automatic logic [31:0] mrg(input logic [31:0] o, n, k);
		return (o & ~k) | (n & k);
	endfunction

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			end_of_test;
		end
	end

	// Memory side: random answer delay, data logged for later checks
	always @(negedge mclk) begin
		go = mem_out.req && !mem_ack && ($random(seed) & 3) == 0;
		if (txv_q && !tx_valid_n && rq.size() > 0) begin
			chk(tx_data, rq.pop_front());
		end
		txv_q = tx_valid_n;
	end
	always @(posedge mclk) begin
		mem_ack <= go;
		if (go && mem_out.we) wq.push_back({mem_out.addr, mem_out.wdata});
		if (go && !mem_out.we) begin
			rv = $random(seed);
			rq.push_back(rv);
			mem_rdata <= rv;
			mem_rpar <= ~^rv ^ rbad;
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		sys_in = '0;
		{mem_ack, go, txv_q} = 3'h1;
		rbad = 1'b0;
		{mem_rdata, mem_rpar} = 33'h1;
		gpi = 4'h0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		#1 chk({30'h0, rx_space_ok_n, system_irq_n}, 32'h1);
		rdc(8'h1c, 32'hffff_ffff);
		for (int i = 0; i < 4; i++) begin
			w = $random(seed);
			wr(8'h04, w);
			rdc(8'h04, {6'h0, w[25:0]});
			wr(8'h08, w & 32'h0000_00ff);
			chk({24'h0, gp_outputs}, {24'h0, w[7:0]});
			wr(8'h20, w);
			rdc(8'h20, 32'h0);
			wr(8'h04, 32'h1 << i);
			gpi <= w[11:8];
			repeat (5) @(posedge mclk);
			rdc(8'h00, {28'h0, w[11:8]});
			#1 chk({31'h0, system_irq_n}, {31'h0, ~w[8 + i]});
		end
		wr(8'h04, 32'h0);
		gpi <= 4'h0;
		m = 32'h0000_ffff;
		wr(8'h1c, m);
		p = $random(seed);
		wr(8'h0c, p);
		wr(8'h10, p);
		w = $random(seed);
		opt.frame(4'b1110, w, 1'b0);
		rdc(8'h0c, mrg(p, w, m));
		w[0] = 1'b1;
		opt.frame(4'b1100, w, 1'b0);
		rdc(8'h14, {8'h0, w[23:0]});
		rdc(8'h18, {24'h0, w[31:24]});
		a = $random(seed);
		opt.frame(4'b1101, a, 1'b0);
		rdc(8'h10, p);
		wr(8'h14, 32'h0);
		repeat (6) @(posedge mclk);
		rdc(8'h10, mrg(p, a, m));
		acc(1'b0, 8'h00, '0);
		chk(rd & 32'h380, 32'h380);
		wr(8'h00, 32'h03ff_fff0);
		rdc(8'h00, 32'h0);
		p = {$random(seed)} & 32'hfff0_0000;
		wr(8'h0c, p);
		wr(8'h14, 32'h3);
		wr(8'h08, 32'h0000_0600);
		w = $random(seed);
		q = $random(seed);
		opt.frame(4'b1011, w, 1'b0);
		opt.frame(4'b1110, a, 1'b0);
		opt.frame(4'b1011, q, 1'b0);
		for (int i = 0; i < 3; i++) begin
			for (int k = 0; k < 200 && tx_valid_n !== 1'b0; k++) @(posedge mclk);
			opt.frame(4'b0111, 32'h0, 1'b0);
		end
		repeat (40) @(posedge mclk);
		chk(wq.size(), 2);
		chk(wq[0][63:32], p);
		chk(wq[0][31:0], w);
		chk(wq[1][63:32], mrg(p + 32'h4, a, m));
		chk(wq[1][31:0], q);
		chk(rq.size(), 0);
		acc(1'b0, 8'h00, '0);
		chk(rd & 32'h40, 32'h40);
		rdc(8'h14, 32'h0);
		wr(8'h00, 32'h03ff_fff0);
		wr(8'h04, 32'h10);
		opt.frame(4'b1011, w, 1'b1);
		rdc(8'h00, 32'h0);
		wr(8'h08, 32'h100);
		opt.frame(4'b1011, q, 1'b1);
		rdc(8'h00, 32'h10);
		#1 chk({31'h0, system_irq_n}, 32'h0);
		// Memory read with bad parity: error and count-done both set
		rbad = 1'b1;
		wr(8'h14, 32'h1);
		wr(8'h08, 32'h0000_0500);
		repeat (40) @(posedge mclk);
		rdc(8'h00, 32'h70);
		end_of_test;
	end
endmodule
`default_nettype wire
